// File: hdl/buck_ctrl_regs.vh
// Offsets, field positions, reset values and timing counts for the buck
// protection and light-load controller. Definitions only; included by name.
`ifndef BUCK_CTRL_REGS_VH
`define BUCK_CTRL_REGS_VH

`define CLK_HZ              10000000
`define REF_STEP_TIME_NS    1000
`define CLK_PERIOD_NS       100
`define REF_STEP_CYCLES     (`REF_STEP_TIME_NS / `CLK_PERIOD_NS)
`define AUDIO_MIN_FREQ_HZ   28000
`define AUDIO_PERIOD_CYCLES (`CLK_HZ / `AUDIO_MIN_FREQ_HZ)
`define VALLEY_OC_CYCLES    8

`define REF_W               10
`define REF_RESET           10'h1E0

`define ADDR_CTRL           4'h0
`define ADDR_STATUS         4'h4

`define ST_UV               0
`define ST_OV               1
`define ST_VALLEY_OC        2
`define ST_HS_OC            3
`define ST_THERMAL          4
`define ST_SS_DONE          5
`define ST_POWER_GOOD_FLAG            6
`define ST_MODE_LSB         8
`define ST_REF_LSB          16

`define MODE_CCM            2'h0
`define MODE_DCM            2'h1
`define MODE_AUDIO          2'h2

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// File: hdl/buck_protection_and_light_load_ctrl.v
// Control and supervision logic for a step-down regulator: light-load mode,
// switch sequencing, fault latching, power-good and soft discharge.
// Assumes comparator inputs from the analog stage are synchronous to MCLK.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "buck_ctrl_regs.vh"

module buck_protection_and_light_load_ctrl #(
    parameter [`REF_W-1:0] REF_RESET_CODE = `REF_RESET
) (
    input  wire        MCLK,
    input  wire        ARST_N,
    input  wire        SUPPLY_OK,
    input  wire        REG_ENABLE,
    input  wire        LIGHT_LOAD_MODE_SELECT,
    input  wire        LIGHT_LOAD_MODE_SELECT_FLOAT,
    input  wire        PWM_ON_REQ,
    input  wire        PWM_ON_END,
    input  wire        ZERO_CURRENT,
    input  wire        CYCLE_VALLEY_STROBE,
    input  wire        VALLEY_OVERCURRENT_TRIP,
    input  wire        HS_OVERCURRENT_TRIP,
    input  wire        UNDERVOLT_CMP,
    input  wire        OVERVOLT_CMP,
    input  wire        ABOVE_REF_CMP,
    input  wire        TEMP_ABOVE_HIGH,
    input  wire        TEMP_ABOVE_LOW,
    output reg         HS_SWITCH_ON,
    output reg         LS_SWITCH_ON,
    output reg         SOFT_DISCHARGE_ON,
    output reg         POWER_GOOD_FLAG,
    output reg  [9:0]  REFERENCE_SETPOINT,
    input  wire [3:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [3:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);

    localparam [1:0] SW_OFF  = 2'h0;
    localparam [1:0] SW_HIGH = 2'h1;
    localparam [1:0] SW_LOW  = 2'h2;
    localparam [1:0] SW_IDLE = 2'h3;

    // Counts are worked out as integers and then cut to the counter widths on purpose.
    localparam integer STEP_LAST_I  = `REF_STEP_CYCLES - 1;
    localparam integer AUDIO_LAST_I = `AUDIO_PERIOD_CYCLES - 1;
    localparam integer VOC_LIMIT_I  = `VALLEY_OC_CYCLES;
    localparam [3:0]   STEP_LAST    = STEP_LAST_I[3:0];
    localparam [8:0]   AUDIO_LAST   = AUDIO_LAST_I[8:0];
    localparam [3:0]   VOC_LIMIT    = VOC_LIMIT_I[3:0];

    reg  [`REF_W-1:0] target_q;
    reg  [3:0]        step_cnt_q;
    reg               ss_done_q;
    reg               uv_q;
    reg               ov_q;
    reg               voc_q;
    reg               hsoc_q;
    reg               ot_q;
    reg  [3:0]        voc_cnt_q;
    reg  [1:0]        sw_state_q;
    reg  [1:0]        sw_state_d;
    reg  [8:0]        period_cnt_q;
    wire              active;
    wire              shutdown;
    wire              any_fault;
    wire [1:0]        mode;
    wire              dcm_allowed;
    wire              audio_expired;
    wire              wr_take;
    wire              rd_take;
    wire [31:0]       status_word;
    wire              wr_ctrl;
    wire              wr_status;
    wire              rd_ctrl;
    wire              rd_status;

    // Logic inputs mean nothing until the supplies are good.
    assign active    = SUPPLY_OK & REG_ENABLE;
    assign shutdown  = uv_q | voc_q | hsoc_q | ot_q;
    assign any_fault = shutdown | ov_q;

    // The float detector has priority, since a floating pin reads as either level.
    assign mode = LIGHT_LOAD_MODE_SELECT_FLOAT ? `MODE_AUDIO :
                  (LIGHT_LOAD_MODE_SELECT ? `MODE_CCM : `MODE_DCM);
    assign dcm_allowed   = (mode != `MODE_CCM);
    assign audio_expired = (mode == `MODE_AUDIO) && (period_cnt_q == AUDIO_LAST);

    // Soft-start and margin slewing: one reference code step per microsecond.
    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REFERENCE_SETPOINT <= 10'h000;
            step_cnt_q         <= 4'h0;
            ss_done_q          <= 1'b0;
        end else if (!active) begin
            REFERENCE_SETPOINT <= 10'h000;
            step_cnt_q         <= 4'h0;
            ss_done_q          <= 1'b0;
        end else if (REFERENCE_SETPOINT == target_q) begin
            step_cnt_q <= 4'h0;
            ss_done_q  <= 1'b1;
        end else if (step_cnt_q == STEP_LAST) begin
            step_cnt_q <= 4'h0;
            if (REFERENCE_SETPOINT < target_q) begin
                REFERENCE_SETPOINT <= REFERENCE_SETPOINT + 10'h001;
            end else begin
                REFERENCE_SETPOINT <= REFERENCE_SETPOINT - 10'h001;
            end
        end else begin
            step_cnt_q <= step_cnt_q + 4'h1;
        end
    end

    // Faults latch while supplied and enabled; dropping enable or supply clears them, except overtemperature while TEMP_ABOVE_LOW holds.
    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            uv_q      <= 1'b0;
            ov_q      <= 1'b0;
            voc_q     <= 1'b0;
            hsoc_q    <= 1'b0;
            ot_q      <= 1'b0;
            voc_cnt_q <= 4'h0;
        end else if (!active) begin
            uv_q      <= 1'b0;
            ov_q      <= 1'b0;
            voc_q     <= 1'b0;
            hsoc_q    <= 1'b0;
            voc_cnt_q <= 4'h0;
            // A cooled die is released by the enable toggle, a hot one is not.
            ot_q      <= ot_q & TEMP_ABOVE_LOW;
        end else begin
            // The undervoltage comparator is meaningless while the reference ramps.
            if (UNDERVOLT_CMP && ss_done_q) begin
                uv_q <= 1'b1;
            end
            if (OVERVOLT_CMP) begin
                ov_q <= 1'b1;
            end
            if (HS_OVERCURRENT_TRIP) begin
                hsoc_q <= 1'b1;
            end
            if (TEMP_ABOVE_HIGH) begin
                ot_q <= 1'b1;
            end
            if (CYCLE_VALLEY_STROBE) begin
                if (!VALLEY_OVERCURRENT_TRIP) begin
                    voc_cnt_q <= 4'h0;
                end else if (voc_cnt_q == VOC_LIMIT - 4'h1) begin
                    voc_q     <= 1'b1;
                    voc_cnt_q <= VOC_LIMIT;
                end else if (voc_cnt_q != VOC_LIMIT) begin
                    voc_cnt_q <= voc_cnt_q + 4'h1;
                end
            end
        end
    end

    // Switch sequencing. Overvoltage and shutdown override the modulator.
    always @* begin
        sw_state_d = sw_state_q;
        if (!active || shutdown || ov_q) begin
            sw_state_d = SW_OFF;
        end else begin
            case (sw_state_q)
                SW_OFF: begin
                    if (PWM_ON_REQ) begin
                        sw_state_d = SW_HIGH;
                    end
                end
                SW_HIGH: begin
                    if (PWM_ON_END) begin
                        sw_state_d = SW_LOW;
                    end
                end
                SW_LOW: begin
                    if (PWM_ON_REQ || audio_expired) begin
                        sw_state_d = SW_HIGH;
                    end else if (dcm_allowed && ZERO_CURRENT) begin
                        sw_state_d = SW_IDLE;
                    end
                end
                SW_IDLE: begin
                    if (PWM_ON_REQ || audio_expired) begin
                        sw_state_d = SW_HIGH;
                    end
                end
                default: begin
                    sw_state_d = SW_OFF;
                end
            endcase
        end
    end

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sw_state_q   <= SW_OFF;
            period_cnt_q <= 9'h000;
        end else begin
            sw_state_q <= sw_state_d;
            // The period is measured from each on pulse to the next.
            if (sw_state_d == SW_HIGH && sw_state_q != SW_HIGH) begin
                period_cnt_q <= 9'h000;
            end else if (period_cnt_q != AUDIO_LAST) begin
                period_cnt_q <= period_cnt_q + 9'h001;
            end
        end
    end

    // Registered pin drivers.
    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HS_SWITCH_ON      <= 1'b0;
            LS_SWITCH_ON      <= 1'b0;
            SOFT_DISCHARGE_ON <= 1'b0;
            POWER_GOOD_FLAG   <= 1'b0;
        end else begin
            HS_SWITCH_ON <= (sw_state_d == SW_HIGH);
            if (active && ov_q && !shutdown) begin
                LS_SWITCH_ON <= ABOVE_REF_CMP;
            end else begin
                LS_SWITCH_ON <= (sw_state_d == SW_LOW);
            end
            SOFT_DISCHARGE_ON <= !REG_ENABLE || shutdown;
            POWER_GOOD_FLAG   <= active && ss_done_q && !any_fault;
        end
    end

    // AXI4-Lite slave: both write channels are taken together in one cycle.
    assign wr_take       = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
    assign S_AXI_AWREADY = wr_take;
    assign S_AXI_WREADY  = wr_take;
    assign rd_take       = S_AXI_ARVALID && !S_AXI_RVALID;
    assign S_AXI_ARREADY = rd_take;

    // Each register is one aligned word, so the two low address bits take no part.
    function addr_hit;
        input [3:0] addr;
        input [3:0] reg_addr;
        begin
            addr_hit = (addr[3:2] == reg_addr[3:2]);
        end
    endfunction

    assign wr_ctrl   = addr_hit(S_AXI_AWADDR, `ADDR_CTRL);
    assign wr_status = addr_hit(S_AXI_AWADDR, `ADDR_STATUS);
    assign rd_ctrl   = addr_hit(S_AXI_ARADDR, `ADDR_CTRL);
    assign rd_status = addr_hit(S_AXI_ARADDR, `ADDR_STATUS);

    assign status_word = {6'h0, REFERENCE_SETPOINT,
                          6'h0, mode,
                          1'b0, POWER_GOOD_FLAG, ss_done_q,
                          ot_q, hsoc_q, voc_q, ov_q, uv_q};

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            target_q     <= REF_RESET_CODE;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `RESP_OKAY;
        end else begin
            if (wr_take) begin
                S_AXI_BVALID <= 1'b1;
                if (wr_ctrl) begin
                    S_AXI_BRESP <= `RESP_OKAY;
                    if (S_AXI_WSTRB[0]) begin
                        target_q[7:0] <= S_AXI_WDATA[7:0];
                    end
                    if (S_AXI_WSTRB[1]) begin
                        target_q[9:8] <= S_AXI_WDATA[9:8];
                    end
                end else if (wr_status) begin
                    S_AXI_BRESP <= `RESP_OKAY;
                end else begin
                    S_AXI_BRESP <= `RESP_SLVERR;
                end
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
            S_AXI_RRESP  <= `RESP_OKAY;
        end else begin
            if (rd_take) begin
                S_AXI_RVALID <= 1'b1;
                if (rd_ctrl) begin
                    S_AXI_RDATA <= {22'h0, target_q};
                    S_AXI_RRESP <= `RESP_OKAY;
                end else if (rd_status) begin
                    S_AXI_RDATA <= status_word;
                    S_AXI_RRESP <= `RESP_OKAY;
                end else begin
                    S_AXI_RDATA <= 32'h00000000;
                    S_AXI_RRESP <= `RESP_SLVERR;
                end
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule // buck_protection_and_light_load_ctrl

// File: verification/buck_ctrl_asserts.sv
// Assertions on the top-level ports of the buck controller.
// Assumes one clock domain, MCLK, and the asynchronous active-low ARST_N.
`timescale 1ns/1ps
module buck_ctrl_checker (
    input wire MCLK,
    input wire ARST_N,
    input wire SUPPLY_OK,
    input wire REG_ENABLE,
    input wire LIGHT_LOAD_MODE_SELECT,
    input wire LIGHT_LOAD_MODE_SELECT_FLOAT,
    input wire PWM_ON_REQ,
    input wire ZERO_CURRENT,
    input wire CYCLE_VALLEY_STROBE,
    input wire VALLEY_OVERCURRENT_TRIP,
    input wire HS_OVERCURRENT_TRIP,
    input wire UNDERVOLT_CMP,
    input wire OVERVOLT_CMP,
    input wire TEMP_ABOVE_HIGH,
    input wire HS_SWITCH_ON,
    input wire LS_SWITCH_ON,
    input wire SOFT_DISCHARGE_ON,
    input wire POWER_GOOD_FLAG
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    wire      run = REG_ENABLE && SUPPLY_OK;
    reg [3:0] vcnt_q;
    // Strobes are ignored while the regulator is off, so the count restarts then too.
    always @(posedge MCLK or negedge ARST_N)
        if (!ARST_N) vcnt_q <= 4'h0;
        else if (!run) vcnt_q <= 4'h0;
        else if (CYCLE_VALLEY_STROBE) vcnt_q <= VALLEY_OVERCURRENT_TRIP ? vcnt_q + 4'h1 : 4'h0;
    valley_trip_a: assert property (CYCLE_VALLEY_STROBE && VALLEY_OVERCURRENT_TRIP && vcnt_q == 4'h7 && run
        |-> ##[1:2] SOFT_DISCHARGE_ON) else $error("Valley overcurrent did not shut down.");
    uv_shutdown_a: assert property (UNDERVOLT_CMP && POWER_GOOD_FLAG && run
        |-> ##[1:2] (SOFT_DISCHARGE_ON && !HS_SWITCH_ON && !LS_SWITCH_ON)) else $error("Undervoltage not handled.");
    hs_oc_off_a: assert property (HS_OVERCURRENT_TRIP && run
        |-> ##[1:2] (!HS_SWITCH_ON && !LS_SWITCH_ON && SOFT_DISCHARGE_ON && !POWER_GOOD_FLAG))
        else $error("High-side overcurrent not handled.");
    ov_flag_a: assert property (OVERVOLT_CMP && run |-> ##[1:2] (!HS_SWITCH_ON && !POWER_GOOD_FLAG))
        else $error("Overvoltage not flagged.");
    ov_hs_latch_a: assert property ((OVERVOLT_CMP && run) ##1 run [*4] |-> !HS_SWITCH_ON)
        else $error("High side left the overvoltage latch.");
    disable_discharge_a: assert property (!REG_ENABLE |=> SOFT_DISCHARGE_ON)
        else $error("Discharge off while disabled.");
    pg_cause_a: assert property ($rose(POWER_GOOD_FLAG) |-> $past(REG_ENABLE) && $past(SUPPLY_OK))
        else $error("Power good rose while off.");
    thermal_pg_a: assert property (TEMP_ABOVE_HIGH |-> ##2 !POWER_GOOD_FLAG)
        else $error("Power good high when hot.");
    // Power good high and no fresh overvoltage keep the overvoltage pull-down out of this check.
    dcm_zero_off_a: assert property (run && POWER_GOOD_FLAG && !$past(OVERVOLT_CMP) && LS_SWITCH_ON
        && !LIGHT_LOAD_MODE_SELECT && !LIGHT_LOAD_MODE_SELECT_FLOAT && ZERO_CURRENT && !PWM_ON_REQ
        |-> ##[1:2] (!HS_SWITCH_ON && !LS_SWITCH_ON)) else $error("Switches not off at zero current.");
    idle_hold_a: assert property ((!HS_SWITCH_ON && !LS_SWITCH_ON && !PWM_ON_REQ
        && !LIGHT_LOAD_MODE_SELECT_FLOAT) [*2] |=> !HS_SWITCH_ON) else $error("High side on without request.");
    cover property (run && POWER_GOOD_FLAG);
    cover property ($rose(HS_SWITCH_ON) && LIGHT_LOAD_MODE_SELECT_FLOAT);
    cover property (CYCLE_VALLEY_STROBE && vcnt_q == 4'h7);
endmodule // buck_ctrl_checker

bind buck_protection_and_light_load_ctrl buck_ctrl_checker checker_inst (
    .MCLK                         (MCLK),
    .ARST_N                       (ARST_N),
    .SUPPLY_OK                    (SUPPLY_OK),
    .REG_ENABLE                   (REG_ENABLE),
    .LIGHT_LOAD_MODE_SELECT       (LIGHT_LOAD_MODE_SELECT),
    .LIGHT_LOAD_MODE_SELECT_FLOAT (LIGHT_LOAD_MODE_SELECT_FLOAT),
    .PWM_ON_REQ                   (PWM_ON_REQ),
    .ZERO_CURRENT                 (ZERO_CURRENT),
    .CYCLE_VALLEY_STROBE          (CYCLE_VALLEY_STROBE),
    .VALLEY_OVERCURRENT_TRIP      (VALLEY_OVERCURRENT_TRIP),
    .HS_OVERCURRENT_TRIP          (HS_OVERCURRENT_TRIP),
    .UNDERVOLT_CMP                (UNDERVOLT_CMP),
    .OVERVOLT_CMP                 (OVERVOLT_CMP),
    .TEMP_ABOVE_HIGH              (TEMP_ABOVE_HIGH),
    .HS_SWITCH_ON                 (HS_SWITCH_ON),
    .LS_SWITCH_ON                 (LS_SWITCH_ON),
    .SOFT_DISCHARGE_ON            (SOFT_DISCHARGE_ON),
    .POWER_GOOD_FLAG              (POWER_GOOD_FLAG)
);

// File: verification/host_model.sv
// Host side: brings the supplies up, then drives the regulator enable.
// Assumes the bench asks for power-up and restarts through want_on.
`timescale 1ns/1ps
module host_model (
    input  wire mclk,
    input  wire want_on,
    output reg  supply_ok,
    output reg  reg_enable
);
    reg [2:0] por_q;
    initial por_q = 3'h0;
    initial supply_ok = 1'b0;
    initial reg_enable = 1'b0;
    always @(posedge mclk) begin
        if (por_q != 3'h7) por_q <= por_q + 3'h1;
        supply_ok  <= (por_q == 3'h7);
        reg_enable <= want_on && supply_ok;
    end
endmodule // host_model

// File: verification/tb_top.sv
// Self-checking bench for the buck controller: registers, modes and faults.
// Assumes the host model for supplies and enable, and the bound checker.
`timescale 1ns/1ps
`include "buck_ctrl_regs.vh"
module tb_top;
    localparam SEL = 0, FLT = 1, REQ = 2, ENDP = 3, ZC = 4, STB = 5, VT = 6, HOC = 7, UV = 8, OV = 9, ABV = 10;
    localparam THI = 11, TLO = 12;
    reg         mclk, arst_n, want_on, awvalid, wvalid, bready, arvalid, rready;
    reg  [12:0] ins;
    reg  [3:0]  awaddr, araddr;
    reg  [31:0] wdata, rd;
    reg  [1:0]  rs;
    wire        supply_ok, reg_enable, hs_on, ls_on, dis_on, pg, awready, wready, bvalid, arready, rvalid;
    wire [9:0]  ref_sp;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    integer     fail_count, total_checks, n;
    host_model host_model_inst (.mclk(mclk), .want_on(want_on), .supply_ok(supply_ok), .reg_enable(reg_enable));
    buck_protection_and_light_load_ctrl buck_protection_and_light_load_ctrl_inst (
        .MCLK(mclk), .ARST_N(arst_n), .SUPPLY_OK(supply_ok), .REG_ENABLE(reg_enable),
        .LIGHT_LOAD_MODE_SELECT(ins[SEL]), .LIGHT_LOAD_MODE_SELECT_FLOAT(ins[FLT]), .PWM_ON_REQ(ins[REQ]),
        .PWM_ON_END(ins[ENDP]), .ZERO_CURRENT(ins[ZC]), .CYCLE_VALLEY_STROBE(ins[STB]),
        .VALLEY_OVERCURRENT_TRIP(ins[VT]), .HS_OVERCURRENT_TRIP(ins[HOC]), .UNDERVOLT_CMP(ins[UV]),
        .OVERVOLT_CMP(ins[OV]), .ABOVE_REF_CMP(ins[ABV]), .TEMP_ABOVE_HIGH(ins[THI]), .TEMP_ABOVE_LOW(ins[TLO]),
        .HS_SWITCH_ON(hs_on), .LS_SWITCH_ON(ls_on), .SOFT_DISCHARGE_ON(dis_on), .POWER_GOOD_FLAG(pg),
        .REFERENCE_SETPOINT(ref_sp), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    task cyc(input integer k);
        repeat (k) @(posedge mclk);
    endtask
    task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
        end
    endtask
    // The leading edge keeps a level change and a pulse out of one time step.
    task pulse(input integer i);
        cyc(1);
        ins[i] <= 1'b1;
        cyc(1);
        ins[i] <= 1'b0;
        cyc(3);
    endtask
    task axw(input [3:0] a, input [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        cyc(1);
        while (!(awready && wready)) cyc(1);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        cyc(1);
        while (!bvalid) cyc(1);
        rs = bresp;
        bready <= 1'b0;
        cyc(1);
    endtask
    task axr(input [3:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        cyc(1);
        while (!arready) cyc(1);
        arvalid <= 1'b0;
        cyc(1);
        while (!rvalid) cyc(1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        cyc(1);
    endtask
    task shut;
        chk("switches", 32'h0, {hs_on, ls_on});
        chk("discharge", 32'h1, dis_on);
        chk("power_good_flag", 32'h0, pg);
    endtask
    task wait_pg(input integer lim);
        n = 0;
        while (pg !== 1'b1 && n < lim) begin
            cyc(1);
            n = n + 1;
        end
    endtask
    task restart(input e);
        want_on <= 1'b0;
        cyc(4);
        chk("discharge", 32'h1, dis_on);
        want_on <= 1'b1;
        wait_pg(400);
        chk("power_good_flag", e, pg);
    endtask
    task t_regs;
        axr(`ADDR_CTRL);
        chk("ctrl reset", {22'h0, `REF_RESET}, rd);
        axw(`ADDR_CTRL, 32'hFFFF_F010);
        axr(`ADDR_CTRL);
        chk("ctrl", 32'h0000_0010, rd);
        axw(`ADDR_STATUS, 32'h0000_FFFF);
        chk("status wr", `RESP_OKAY, rs);
        axr(4'h8);
        chk("unmapped", `RESP_SLVERR, rs);
        $display("regs test done");
    endtask
    task t_start;
        want_on <= 1'b1;
        wait_pg(1000);
        chk("ramp time", 32'h1, n >= 160);
        chk("reference", 32'h10, ref_sp);
        chk("power_good_flag", 32'h1, pg);
        $display("start test done");
    endtask
    task t_modes;
        ins[SEL] <= 1'b1;
        pulse(REQ);
        chk("hs ccm", 32'h1, hs_on);
        pulse(ENDP);
        pulse(ZC);
        chk("ls ccm", 32'h1, ls_on);
        axr(`ADDR_STATUS);
        chk("mode ccm", `MODE_CCM, rd[9:8]);
        ins[SEL] <= 1'b0;
        pulse(ZC);
        chk("dcm off", 32'h0, {hs_on, ls_on});
        cyc(20);
        chk("dcm idle", 32'h0, {hs_on, ls_on});
        axr(`ADDR_STATUS);
        chk("mode dcm", `MODE_DCM, rd[9:8]);
        ins[FLT] <= 1'b1;
        pulse(REQ);
        pulse(ENDP);
        pulse(ZC);
        n = 0;
        while (hs_on !== 1'b1 && n < 500) begin
            cyc(1);
            n = n + 1;
        end
        chk("audio pulse", 32'h1, hs_on);
        chk("audio delay", 32'h1, n > 300);
        axr(`ADDR_STATUS);
        chk("mode audio", `MODE_AUDIO, rd[9:8]);
        ins[FLT] <= 1'b0;
        pulse(ENDP);
        $display("modes test done");
    endtask
    task t_faults;
        for (n = 0; n < 16; n = n + 1) begin
            ins[VT:STB] <= {n != 7, 1'b1};
            cyc(1);
            ins[VT:STB] <= 2'b00;
            cyc(1);
            if (n == 14) chk("valley held", 32'h1, pg);
        end
        cyc(3);
        shut;
        restart(1'b1);
        pulse(UV);
        shut;
        cyc(10);
        chk("uv latched", 32'h0, pg);
        restart(1'b1);
        pulse(HOC);
        shut;
        restart(1'b1);
        ins[ABV] <= 1'b1;
        pulse(OV);
        chk("ov outputs", 32'h2, {pg, hs_on, ls_on, dis_on});
        ins[ABV] <= 1'b0;
        cyc(3);
        chk("ov low side", 32'h0, ls_on);
        ins[ABV] <= 1'b1;
        cyc(3);
        chk("ov repeat", 32'h2, {pg, hs_on, ls_on, dis_on});
        ins[ABV] <= 1'b0;
        restart(1'b1);
        ins[TLO:THI] <= 2'b11;
        cyc(4);
        shut;
        ins[TLO:THI] <= 2'b10;
        restart(1'b0);
        ins[TLO:THI] <= 2'b00;
        restart(1'b1);
        $display("faults test done");
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        {arst_n, want_on, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {ins, awaddr, araddr, wdata} = 53'h0;
        fail_count = 0;
        total_checks = 0;
        cyc(3);
        arst_n <= 1'b1;
        cyc(10);
        t_regs;
        t_start;
        t_modes;
        t_faults;
        test_done;
    end
    // About five times the expected run length.
    initial begin
        #1000000;
        fail_count = fail_count + 1;
        test_done;
    end
endmodule // tb_top
